// ---- logic/color_matrix_pkg.sv ----
// Package of offsets, field layouts and reset values for the colour matrix
package color_matrix_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned COEF_W = 12;
    localparam int unsigned OFST_W = 13;
    localparam int unsigned PIX_W = 12;
    localparam int unsigned NUM_REGS = 12;
    localparam int unsigned FRAC_BITS = 8;

    localparam logic [ADDR_W-1:0] OFF_COEF_RR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COEF_GR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COEF_BR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COEF_RG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_COEF_GG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_COEF_BG = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_COEF_RB = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_COEF_GB = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_COEF_BB = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_OFST_R = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_OFST_G = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_OFST_B = 8'h2C;

    localparam logic [COEF_W-1:0] COEF_UNITY = 12'h100;
    localparam logic [COEF_W-1:0] COEF_ZERO = 12'h000;
    localparam logic [OFST_W-1:0] OFST_ZERO = 13'h0000;
    // Index of the first offset register in the flat register array
    localparam int unsigned FIRST_OFST_IDX = 9;
endpackage

// ---- logic/first_color_matrix_stage.sv ----
// Register bank and pixel datapath of the first colour matrix stage
`timescale 1ns/1ps
// Notes on behaviour
// Coefficients are 12-bit signed 4.8 fields
// Green-to-green coefficient resets to 256
// Blue-to-blue coefficient resets to 256
// Off-diagonal coefficients reset to zero
// Upper bits read zero; software writes zero
// Red, green offsets 13-bit signed, reset zero
// Red-to-red coefficient resets to 256
// Blue offset 13-bit signed, resets zero
// Output is row-weighted sum plus offset, clipped
module first_color_matrix_stage (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [color_matrix_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic pix_valid_i,
    input wire logic [color_matrix_pkg::PIX_W-1:0] pix_red_i,
    input wire logic [color_matrix_pkg::PIX_W-1:0] pix_green_i,
    input wire logic [color_matrix_pkg::PIX_W-1:0] pix_blue_i,
    output logic pix_valid_o,
    output logic [color_matrix_pkg::PIX_W-1:0] pix_red_o,
    output logic [color_matrix_pkg::PIX_W-1:0] pix_green_o,
    output logic [color_matrix_pkg::PIX_W-1:0] pix_blue_o
);
    import color_matrix_pkg::*;

    localparam int unsigned ACC_W = 28;

    ////////////////////////////////////////////////////////////////////////
    // Register bank: 9 coefficients then 3 offsets, 13-bit storage each
    logic [OFST_W-1:0] regs_q [NUM_REGS];
    logic [OFST_W-1:0] regs_d [NUM_REGS];
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic err_q, err_d;

    logic req;
    logic hit;
    logic [3:0] idx;
    logic [4:0] slot;
    logic wr_en;
    logic rd_en;

    function automatic logic [OFST_W-1:0] reset_value(input int unsigned i);
        case (i)
            0: reset_value = {1'b0, COEF_UNITY};
            1, 2, 3: reset_value = {1'b0, COEF_ZERO};
            4: reset_value = {1'b0, COEF_UNITY};
            5, 6, 7: reset_value = {1'b0, COEF_ZERO};
            8: reset_value = {1'b0, COEF_UNITY};
            default: reset_value = OFST_ZERO;
        endcase
    endfunction

    function automatic logic [OFST_W-1:0] field_mask(input int unsigned i);
        if (i < FIRST_OFST_IDX) begin
            field_mask = {1'b0, {COEF_W{1'b1}}};
        end else begin
            field_mask = {OFST_W{1'b1}};
        end
    endfunction

    // Byte address to register index; bit 4 set on a miss
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_COEF_RR: decode = 5'h00;
            OFF_COEF_GR: decode = 5'h01;
            OFF_COEF_BR: decode = 5'h02;
            OFF_COEF_RG: decode = 5'h03;
            OFF_COEF_GG: decode = 5'h04;
            OFF_COEF_BG: decode = 5'h05;
            OFF_COEF_RB: decode = 5'h06;
            OFF_COEF_GB: decode = 5'h07;
            OFF_COEF_BB: decode = 5'h08;
            OFF_OFST_R: decode = 5'h09;
            OFF_OFST_G: decode = 5'h0A;
            OFF_OFST_B: decode = 5'h0B;
            default: decode = 5'h10;
        endcase
    endfunction

    // Byte-lane merge of a write; bits outside the field stay zero
    // Only the two low byte lanes can reach a field
    function automatic logic [OFST_W-1:0] merge(
        input logic [OFST_W-1:0] old,
        input logic [31:0] data,
        input logic [3:0] sel,
        input logic [OFST_W-1:0] mask
    );
        logic [OFST_W-1:0] upd;
        upd = old;
        if (sel[0]) begin
            upd[7:0] = data[7:0];
        end
        if (sel[1]) begin
            upd[12:8] = data[12:8];
        end
        merge = upd & mask;
    endfunction

    assign slot = decode(wb_adr_i);
    assign hit = !slot[4];
    assign idx = slot[3:0];
    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    // Write and read strobes for the accepted request
    assign wr_en = req && hit && wb_we_i;
    assign rd_en = req && hit && !wb_we_i;

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        ack_d = req && hit;
        err_d = req && !hit;
        rdata_d = 32'h0000_0000;
        if (wr_en) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (idx == 4'(i)) begin
                    regs_d[i] = merge(regs_q[i], wb_dat_i, wb_sel_i,
                        field_mask(i));
                end
            end
        end
        if (rd_en) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (idx == 4'(i)) begin
                    // Reserved bits above each field read as zero
                    rdata_d = {19'h0, regs_q[i] & field_mask(i)};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= reset_value(i);
            end
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    ////////////////////////////////////////////////////////////////////////
    // Named views of the stored fields; unity gain sits at 256
    logic [COEF_W-1:0] coef_red_to_red;
    logic [COEF_W-1:0] coef_green_to_red;
    logic [COEF_W-1:0] coef_blue_to_red;
    logic [COEF_W-1:0] coef_red_to_green;
    logic [COEF_W-1:0] coef_green_to_green;
    logic [COEF_W-1:0] coef_blue_to_green;
    logic [COEF_W-1:0] coef_red_to_blue;
    logic [COEF_W-1:0] coef_green_to_blue;
    logic [COEF_W-1:0] coef_blue_to_blue;

    // Offsets are signed whole numbers
    logic [OFST_W-1:0] red_output_offset;
    logic [OFST_W-1:0] green_output_offset;
    logic [OFST_W-1:0] blue_output_offset;

    assign coef_red_to_red = regs_q[0][COEF_W-1:0];
    assign coef_green_to_red = regs_q[1][COEF_W-1:0];
    assign coef_blue_to_red = regs_q[2][COEF_W-1:0];
    assign coef_red_to_green = regs_q[3][COEF_W-1:0];
    assign coef_green_to_green = regs_q[4][COEF_W-1:0];
    assign coef_blue_to_green = regs_q[5][COEF_W-1:0];
    assign coef_red_to_blue = regs_q[6][COEF_W-1:0];
    assign coef_green_to_blue = regs_q[7][COEF_W-1:0];
    assign coef_blue_to_blue = regs_q[8][COEF_W-1:0];

    assign red_output_offset = regs_q[9];
    assign green_output_offset = regs_q[10];
    assign blue_output_offset = regs_q[11];

    ////////////////////////////////////////////////////////////////////////
    // Pixel datapath: nine products, three row sums, one registered stage
    localparam int ROUND_HALF = 1 << (FRAC_BITS - 1);
    localparam int PIX_MAX = (1 << PIX_W) - 1;

    function automatic logic signed [ACC_W-1:0] mul(
        input logic [PIX_W-1:0] pix,
        input logic [COEF_W-1:0] coef
    );
        logic signed [COEF_W-1:0] c;
        logic signed [PIX_W:0] p;
        c = $signed(coef);
        p = $signed({1'b0, pix});
        mul = ACC_W'(p * c);
    endfunction

    // Round half up, drop the fraction, add the offset, clip to range
    function automatic logic [PIX_W-1:0] round_clip(
        input logic signed [ACC_W-1:0] sum,
        input logic [OFST_W-1:0] ofs
    );
        logic signed [ACC_W-1:0] res;
        res = ((sum + ACC_W'(ROUND_HALF)) >>> FRAC_BITS)
            + ACC_W'($signed(ofs));
        if (res < 0) begin
            round_clip = '0;
        end else if (res > ACC_W'(PIX_MAX)) begin
            round_clip = '1;
        end else begin
            round_clip = res[PIX_W-1:0];
        end
    endfunction

    // Products of each input with each row coefficient
    logic signed [ACC_W-1:0] prod_rr;
    logic signed [ACC_W-1:0] prod_gr;
    logic signed [ACC_W-1:0] prod_br;
    logic signed [ACC_W-1:0] prod_rg;
    logic signed [ACC_W-1:0] prod_gg;
    logic signed [ACC_W-1:0] prod_bg;
    logic signed [ACC_W-1:0] prod_rb;
    logic signed [ACC_W-1:0] prod_gb;
    logic signed [ACC_W-1:0] prod_bb;

    logic signed [ACC_W-1:0] sum_red;
    logic signed [ACC_W-1:0] sum_green;
    logic signed [ACC_W-1:0] sum_blue;

    assign prod_rr = mul(pix_red_i, coef_red_to_red);
    assign prod_gr = mul(pix_green_i, coef_green_to_red);
    assign prod_br = mul(pix_blue_i, coef_blue_to_red);
    assign prod_rg = mul(pix_red_i, coef_red_to_green);
    assign prod_gg = mul(pix_green_i, coef_green_to_green);
    assign prod_bg = mul(pix_blue_i, coef_blue_to_green);
    assign prod_rb = mul(pix_red_i, coef_red_to_blue);
    assign prod_gb = mul(pix_green_i, coef_green_to_blue);
    assign prod_bb = mul(pix_blue_i, coef_blue_to_blue);

    // Full precision row sums; nothing is dropped before rounding
    assign sum_red = prod_rr + prod_gr + prod_br;
    assign sum_green = prod_rg + prod_gg + prod_bg;
    assign sum_blue = prod_rb + prod_gb + prod_bb;

    logic valid_q;
    logic valid_d;
    logic [PIX_W-1:0] red_q;
    logic [PIX_W-1:0] red_d;
    logic [PIX_W-1:0] green_q;
    logic [PIX_W-1:0] green_d;
    logic [PIX_W-1:0] blue_q;
    logic [PIX_W-1:0] blue_d;

    // Colour outputs hold their last value while no pixel is offered; valid drops
    always_comb begin
        valid_d = pix_valid_i;
        red_d = red_q;
        green_d = green_q;
        blue_d = blue_q;
        if (pix_valid_i) begin
            red_d = round_clip(sum_red, red_output_offset);
            green_d = round_clip(sum_green, green_output_offset);
            blue_d = round_clip(sum_blue, blue_output_offset);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            red_q <= '0;
            green_q <= '0;
            blue_q <= '0;
        end else begin
            valid_q <= valid_d;
            red_q <= red_d;
            green_q <= green_d;
            blue_q <= blue_d;
        end
    end

    assign pix_valid_o = valid_q;
    assign pix_red_o = red_q;
    assign pix_green_o = green_q;
    assign pix_blue_o = blue_q;

endmodule // first_color_matrix_stage

// ---- testbench/color_matrix_sva.sv ----
// Assertion checker for the colour matrix bus and pixel path
`timescale 1ns/1ps
module color_matrix_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [color_matrix_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic pix_valid_i,
    input wire logic pix_valid_o,
    input wire logic [color_matrix_pkg::PIX_W-1:0] pix_red_o
);
    import color_matrix_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    ////////////////////////////////////////////////////////////////////
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_req_answered: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered next cycle");
    a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    a_dat_idle_zero: assert property (!(wb_ack_o && !$past(wb_we_i))
        |-> wb_dat_o == 32'h0)
        else $error("read data outside read ack");
    a_coef_upper_zero: assert property (wb_ack_o
        && $past(wb_adr_i) <= 8'h20 |-> wb_dat_o[31:12] == 20'h0)
        else $error("coefficient upper bits set");
    a_ofst_upper_zero: assert property (wb_ack_o
        |-> wb_dat_o[31:13] == 19'h0)
        else $error("offset upper bits set");
    a_misalign_err: assert property (req && wb_adr_i[1:0] != 2'h0
        |=> wb_err_o && !wb_ack_o)
        else $error("misaligned access not refused");
    a_pix_latency: assert property (pix_valid_i |=> pix_valid_o)
        else $error("pixel result late");
    a_pix_hold: assert property (!pix_valid_o |-> $stable(pix_red_o))
        else $error("pixel output moved without valid");
    c_read: cover property (wb_ack_o && !$past(wb_we_i));
    c_err: cover property (wb_err_o);
    c_pix: cover property (pix_valid_o);
endmodule // color_matrix_sva

bind first_color_matrix_stage color_matrix_sva chk_i (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .pix_valid_i, .pix_valid_o, .pix_red_o);

// ---- testbench/tb_top.sv ----
// Self-checking bench for the first colour matrix stage
`timescale 1ns/1ps
module tb_top;
    import color_matrix_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, exp_val;
    logic pix_valid_i, pix_valid_o;
    logic [PIX_W-1:0] pix_red_i, pix_green_i, pix_blue_i;
    logic [PIX_W-1:0] pix_red_o, pix_green_o, pix_blue_o;
    int n_errors = 0;
    int num_checks = 0;
    first_color_matrix_stage uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .wb_err_o, .pix_valid_i, .pix_red_i, .pix_green_i, .pix_blue_i,
        .pix_valid_o, .pix_red_o, .pix_green_o, .pix_blue_o);
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic er);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(wb_ack_o || wb_err_o) && n < 20);
        if (n >= 20) n_errors++;
        q = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic reset_values();
        for (int i = 0; i < 12; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0, rd, e);
            exp_val = (i % 4 == 0 && i < 9) ? 32'h100 : 32'h0;
            chk(rd, exp_val);
        end
    endtask
    task automatic write_readback();
        for (int i = 0; i < 12; i++) begin
            exp_val = (i < 9) ? 32'h0000_0FFF : 32'h0000_1FFF;
            wb(1'b1, 8'(i * 4), exp_val, rd, e);
            wb(1'b0, 8'(i * 4), 32'h0, rd, e);
            chk(rd, exp_val);
        end
    endtask
    task automatic bus_errors();
        wb(1'b0, 8'h30, 32'h0, rd, e);
        chk({31'h0, e}, 32'h1);
        wb(1'b1, 8'h02, 32'h0, rd, e);
        chk({31'h0, e}, 32'h1);
        wb(1'b0, OFF_COEF_RR, 32'h0, rd, e);
        chk(rd, 32'hFFF);
    endtask
    task automatic pixel_math();
        wb(1'b1, OFF_COEF_GR, 32'h080, rd, e);
        wb(1'b1, OFF_OFST_R, 32'h1FFF, rd, e);
        wb(1'b1, OFF_OFST_B, 32'h0FFF, rd, e);
        wb(1'b1, OFF_COEF_BG, 32'h0000_0F80, rd, e);
        @(posedge clk_i);
        pix_valid_i <= 1'b1;
        {pix_red_i, pix_green_i, pix_blue_i} <= {12'd100, 12'd200, 12'd10};
        @(posedge clk_i);
        pix_valid_i <= 1'b0;
        {pix_red_i, pix_green_i, pix_blue_i} <= 36'h0;
        #1;
        chk({31'h0, pix_valid_o}, 32'h1);
        exp_val = (100 * 256 + 200 * 128 + 128) / 256 - 1;
        chk({20'h0, pix_red_o}, exp_val);
        exp_val = (200 * 256 - 10 * 128 + 128) / 256;
        chk({20'h0, pix_green_o}, exp_val);
        chk({20'h0, pix_blue_o}, 32'd4095);
        @(posedge clk_i);
        #1;
        chk({31'h0, pix_valid_o}, 32'h0);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pix_valid_i} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {pix_red_i, pix_green_i, pix_blue_i} = 36'h0;
        do_reset();
        reset_values();
        write_readback();
        bus_errors();
        do_reset();
        pixel_math();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb_top
